// [hdl/uart_line_defs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef UART_LINE_DEFS_SVH
`define UART_LINE_DEFS_SVH

`define ADDR_DATA 3'h0
`define ADDR_FCR 3'h2
`define ADDR_LCR 3'h3

`define LCR_DLAB 7
`define LCR_BREAK 6
`define LCR_PAR_EN 3
`define LCR_STOP 2
`define FCR_ENABLE 0
`define FCR_FLUSH_RX 1
`define FCR_FLUSH_TX 2
`define FCR_TX_TRIG 3
`define FCR_DEPTH 5

`define LCR_UNLOCK 8'hBF
`define LCR_RESET 8'h00
`define DEPTH_BYTE 8'h01
`define DEPTH_SMALL 8'h10
`define DEPTH_LARGE 8'h80
`define THR_ONE 8'h01
`define THR_NONE 8'h00

`define TX_TRIG_TABLE 32'h7040_2010
`define RX_TRIG_SMALL 32'h0E08_0401
`define RX_TRIG_LARGE 32'h7040_2001
`define RX_UPPER_ENH 32'h7870_2010
`define RX_LOWER_ENH 32'h7020_1001

`define BIT_CYCLES_DEF 16

`endif

// [hdl/uart_line_pkg.sv]
// Types shared by the serial channel queue and line logic
package uart_line_pkg;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'h01,
        RX_START = 5'h02,
        RX_DATA  = 5'h04,
        RX_PAR   = 5'h08,
        RX_STOP  = 5'h10
    } rx_state_t;

    typedef enum logic [4:0] {
        TX_IDLE  = 5'h01,
        TX_START = 5'h02,
        TX_DATA  = 5'h04,
        TX_PAR   = 5'h08,
        TX_STOP  = 5'h10
    } tx_state_t;

    typedef struct packed {
        logic [7:0] line_format_control;
        logic unlock;
        logic fcr_en;
        logic fcr3;
        logic [1:0] fcr54;
        logic [1:0] fcr76;
        logic [6:0] tx_hd;
        logic [6:0] tx_tl;
        logic [7:0] tx_cnt;
        logic [6:0] rx_hd;
        logic [6:0] rx_tl;
        logic [7:0] rx_cnt;
        logic [7:0] rdata;
        logic rx9;
        logic sin_m;
        logic sin_s;
        logic sin_p;
        rx_state_t rx_st;
        logic [15:0] rx_cyc;
        logic [3:0] rx_bit;
        logic [8:0] rx_data;
        logic rx_perr;
        logic perr;
        logic ferr;
        logic ovr;
        tx_state_t tx_st;
        logic [15:0] tx_cyc;
        logic [3:0] tx_bit;
        logic [8:0] tx_data;
        logic serial_output;
    } core_t;

endpackage

// [hdl/tx_skid_buffer.sv]
// Two-entry valid/ready buffer between transmit queue and shifter
`timescale 1ns/1ps
`default_nettype none

module tx_skid_buffer #(
    parameter int W = 9
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    import uart_line_pkg::*;

    typedef struct packed {
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic [1:0] n;
    } skid_t;

    skid_t q;
    skid_t d;
    logic push;
    logic pop;

    assign in_ready_out = (q.n != 2'h2);
    assign out_valid_out = (q.n != 2'h0);
    assign out_data_out = q.e0;

    always_comb begin
        d = q;
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        if (pop) begin
            d.e0 = q.e1;
            d.n = q.n - 2'h1;
        end
        if (push) begin
            if (d.n == 2'h0) begin
                d.e0 = in_data_in;
            end else begin
                d.e1 = in_data_in;
            end
            d.n = d.n + 2'h1;
        end
        // Flushed words must not reach the line
        if (flush_in) begin
            d.n = 2'h0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule // tx_skid_buffer

`default_nettype wire

// [hdl/uart_fifo_line_format.sv]
// Serial channel queues, trigger levels and character framing
// What this block does
// RULE1: Transmitter takes next queue head after each character; idle when all empty.
// RULE2: Single-byte mode holds one entry; queued mode holds 16 or 128.
// RULE3: Writes to a full transmit queue are dropped; empty reads undefined.
// RULE4: Queue-control bit 0 picks single-byte (0) or queued (1) mode.
// RULE5: Bits 1 and 2 flush receive/transmit queue in queued mode; mode change flushes receive.
// RULE6: With bit 3 clear, transmit threshold is 1 and bits 5:4 ignored.
// RULE7: Enhanced mode with bit 3 set: transmit threshold 16, 32, 64, 112.
// RULE8: Transmit interrupt when transmit fill level is below the threshold.
// RULE9: Non-enhanced mode: transmit threshold 1, bit 5 picks 16 or 128 depth.
// RULE10: Bit 5 writable only with divisor access or pin high; enhanced gives 128. The code also takes the bit 5 write in enhanced mode.
// RULE11: Extra-control threshold select takes thresholds from dedicated registers.
// RULE12: Basic 16-deep receive thresholds 1, 4, 8, 14; single-byte uses 1.
// RULE13: 128-deep non-enhanced receive thresholds 1, 32, 64, 112, lower level 1.
// RULE14: Enhanced receive upper 16, 32, 112, 120; lower 1, 16, 32, 112.
// RULE15: Receive interrupt when receive fill level reaches the upper threshold.
// RULE16: Falling edge, wait half bit, accept start only if line still low.
// RULE17: After first stop bit store character, then wait for next falling edge.
// RULE18: Full queue or disabled receiver keeps framing but stores nothing; full flags overrun.
// RULE19: Writing 0xBF sets only the divisor-access bit and exposes extra registers.
// RULE20: Format bits 1:0 give 5 to 8 data bits; ignored in nine-bit framing.
// RULE21: Stop bit 2 gives 1, or 1.5 for 5 bits, else 2.
// RULE22: Bits 5:3 pick none, odd, even or forced-one parity; nine-bit disables.
// RULE23: Parity code 111 sends and expects a zero parity bit.
// RULE24: Format bit 6 holds the serial output low until cleared.
// RULE25: Host push and pop run beside the engines; counts update same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "uart_line_defs.svh"

module uart_fifo_line_format #(
    parameter int BIT_CYCLES = `BIT_CYCLES_DEF
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [2:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    input wire logic tx_ninth_in,
    output logic rx_ninth_out,
    input wire logic enhanced_mode_in,
    input wire logic nine_bit_config_in,
    input wire logic rx_disable_in,
    input wire logic thr_sel_in,
    input wire logic [6:0] tx_thr_reg_in,
    input wire logic [6:0] rx_thr_reg_in,
    input wire logic depth_select_pin_in,
    input wire logic tx_irq_en_in,
    input wire logic rx_irq_en_in,
    input wire logic serial_input_in,
    output logic serial_output_out,
    output logic [7:0] tx_fill_level_out,
    output logic [7:0] rx_fill_level_out,
    output logic [7:0] lower_flow_level_out,
    output logic tx_int_out,
    output logic rx_int_out,
    output logic tx_idle_out,
    output logic overrun_out,
    output logic parity_err_out,
    output logic framing_err_out
);
    import uart_line_pkg::*;

    localparam logic [15:0] BITC = 16'(BIT_CYCLES);
    localparam logic [15:0] HALFC = (BITC > 16'h1) ? (BITC >> 1) : 16'h1;

    core_t q;
    core_t d;
    logic [8:0] tx_mem [0:127];
    logic [8:0] rx_mem [0:127];
    logic [7:0] depth;
    logic [7:0] tx_thr;
    logic [7:0] rx_up;
    logic tx_full;
    logic rx_full;
    logic big;
    logic nine;
    logic [3:0] nbits;
    logic par_on;
    logic [15:0] stop_len;
    logic wr_tx;
    logic rd_rx;
    logic wr_fcr;
    logic wr_lcr;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic flush_rx;
    logic flush_tx;
    logic tx_end;
    logic rx_end;
    logic line;
    logic buf_in_ready;
    logic buf_valid;
    logic buf_ready;
    logic [8:0] buf_data;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    function automatic logic [7:0] thr_pick(input logic [1:0] c,
                                            input logic [31:0] t);
        thr_pick = t[{c, 3'h0} +: 8];
    endfunction

    function automatic logic par_calc(input logic [8:0] v,
                                      input logic [7:0] lc);
        logic [8:0] m;
        m = v & (9'h0FF >> (2'h3 - lc[1:0]));
        case (lc[5:4])
            2'h0: par_calc = ~^m;
            2'h1: par_calc = ^m;
            2'h2: par_calc = 1'b1;
            default: par_calc = 1'b0; // RULE23
        endcase
    endfunction

    // ------------------------------------------------------------
    // Queue depth and trigger levels
    // ------------------------------------------------------------
    assign big = enhanced_mode_in || q.fcr54[1]; // RULE10
    assign depth = !q.fcr_en ? `DEPTH_BYTE :
                   big ? `DEPTH_LARGE : `DEPTH_SMALL; // RULE2 RULE4 RULE9
    assign tx_full = (q.tx_cnt >= depth);
    assign rx_full = (q.rx_cnt >= depth);

    always_comb begin
        if (!q.fcr_en) begin
            tx_thr = `THR_ONE;
            rx_up = `THR_ONE; // RULE12
            lower_flow_level_out = `THR_ONE;
        end else if (thr_sel_in) begin
            tx_thr = {1'b0, tx_thr_reg_in}; // RULE11
            rx_up = {1'b0, rx_thr_reg_in};
            lower_flow_level_out = `THR_ONE;
        end else if (enhanced_mode_in) begin
            tx_thr = q.fcr3 ? thr_pick(q.fcr54, `TX_TRIG_TABLE)
                            : `THR_ONE; // RULE6 RULE7
            rx_up = thr_pick(q.fcr76, `RX_UPPER_ENH); // RULE14
            lower_flow_level_out = thr_pick(q.fcr76, `RX_LOWER_ENH);
        end else if (big) begin
            tx_thr = `THR_ONE; // RULE9
            rx_up = thr_pick(q.fcr76, `RX_TRIG_LARGE); // RULE13
            lower_flow_level_out = `THR_ONE;
        end else begin
            tx_thr = `THR_ONE;
            rx_up = thr_pick(q.fcr76, `RX_TRIG_SMALL); // RULE12
            lower_flow_level_out = `THR_NONE;
        end
    end

    assign tx_int_out = tx_irq_en_in && (q.tx_cnt < tx_thr); // RULE8
    assign rx_int_out = rx_irq_en_in && (q.rx_cnt >= rx_up); // RULE15
    assign tx_fill_level_out = q.tx_cnt;
    assign rx_fill_level_out = q.rx_cnt;
    assign tx_idle_out = (q.tx_cnt == 8'h00) && !buf_valid &&
                         (q.tx_st == TX_IDLE); // RULE1

    // ------------------------------------------------------------
    // Character format
    // ------------------------------------------------------------
    assign nine = nine_bit_config_in;
    assign nbits = nine ? 4'h9 : 4'h5 + {2'h0, q.line_format_control[1:0]}; // RULE20
    assign par_on = q.line_format_control[`LCR_PAR_EN] && !nine; // RULE22
    assign stop_len = !q.line_format_control[`LCR_STOP] ? BITC :
                      (q.line_format_control[1:0] == 2'h0) ? BITC + (BITC >> 1) :
                      (BITC << 1); // RULE21

    // ------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------
    assign wr_tx = wr_in && addr_in == `ADDR_DATA && !q.line_format_control[`LCR_DLAB];
    assign rd_rx = rd_in && addr_in == `ADDR_DATA && !q.line_format_control[`LCR_DLAB];
    assign wr_fcr = wr_in && addr_in == `ADDR_FCR && !q.unlock;
    assign wr_lcr = wr_in && addr_in == `ADDR_LCR;
    assign flush_rx = wr_fcr && ((wdata_in[`FCR_FLUSH_RX] && q.fcr_en) ||
                      (wdata_in[`FCR_ENABLE] != q.fcr_en)); // RULE5
    assign flush_tx = wr_fcr && wdata_in[`FCR_FLUSH_TX] && q.fcr_en;
    assign tx_push = wr_tx && !tx_full; // RULE3
    assign rx_pop = rd_rx && (q.rx_cnt != 8'h00);
    assign tx_pop = (q.tx_cnt != 8'h00) && buf_in_ready;
    assign tx_end = (q.tx_cyc == BITC - 16'h1);
    assign rx_end = (q.rx_cyc == BITC - 16'h1);
    assign rx_push = (q.rx_st == RX_STOP) && rx_end && !rx_full &&
                     !rx_disable_in && !flush_rx; // RULE17 RULE18
    assign buf_ready = (q.tx_st == TX_IDLE); // RULE1

    tx_skid_buffer #(
        .W(9)
    ) u_tx_buf (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .flush_in(flush_tx),
        .in_valid_in(q.tx_cnt != 8'h00),
        .in_ready_out(buf_in_ready),
        .in_data_in(tx_mem[q.tx_hd]),
        .out_valid_out(buf_valid),
        .out_ready_in(buf_ready),
        .out_data_out(buf_data)
    );

    always_ff @(posedge ref_clk_in) begin
        if (tx_push) begin
            tx_mem[q.tx_tl] <= {tx_ninth_in, wdata_in};
        end
        if (rx_push) begin
            rx_mem[q.rx_tl] <= q.rx_data;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        line = 1'b1;
        d.ovr = 1'b0;
        d.sin_m = serial_input_in;
        d.sin_s = q.sin_m;
        d.sin_p = q.sin_s;
        if (wr_lcr) begin
            if (wdata_in == `LCR_UNLOCK) begin
                d.line_format_control[`LCR_DLAB] = 1'b1; // RULE19
                d.unlock = 1'b1;
            end else begin
                d.line_format_control = wdata_in;
                d.unlock = 1'b0;
            end
        end
        if (wr_fcr) begin
            d.fcr_en = wdata_in[`FCR_ENABLE]; // RULE4
            d.fcr3 = wdata_in[`FCR_TX_TRIG];
            d.fcr54[0] = wdata_in[4];
            if (enhanced_mode_in || depth_select_pin_in ||
                q.line_format_control[`LCR_DLAB]) begin
                d.fcr54[1] = wdata_in[`FCR_DEPTH]; // RULE10
            end
            d.fcr76 = wdata_in[7:6];
        end
        if (rd_in) begin
            d.rdata = 8'h00;
            if (rd_rx) begin
                d.rdata = rx_mem[q.rx_hd][7:0]; // RULE3
                d.rx9 = rx_mem[q.rx_hd][8];
            end else if (addr_in == `ADDR_LCR) begin
                d.rdata = q.line_format_control;
            end
        end
        // Queue pointers and counts move together each cycle
        if (tx_push) begin
            d.tx_tl = q.tx_tl + 7'h1;
        end
        if (tx_pop) begin
            d.tx_hd = q.tx_hd + 7'h1;
        end
        d.tx_cnt = q.tx_cnt + {7'h0, tx_push} - {7'h0, tx_pop}; // RULE25
        if (flush_tx) begin
            d.tx_hd = 7'h0;
            d.tx_tl = 7'h0;
            d.tx_cnt = 8'h00;
        end
        if (rx_push) begin
            d.rx_tl = q.rx_tl + 7'h1;
        end
        if (rx_pop) begin
            d.rx_hd = q.rx_hd + 7'h1;
        end
        d.rx_cnt = q.rx_cnt + {7'h0, rx_push} - {7'h0, rx_pop}; // RULE25
        if (flush_rx) begin
            d.rx_hd = 7'h0;
            d.rx_tl = 7'h0;
            d.rx_cnt = 8'h00;
        end
        // Transmit shifter
        d.tx_cyc = q.tx_cyc + 16'h1;
        case (q.tx_st)
            TX_IDLE: begin
                if (buf_valid) begin
                    d.tx_data = buf_data; // RULE1
                    d.tx_st = TX_START;
                    d.tx_cyc = 16'h0;
                end
            end
            TX_START: begin
                line = 1'b0;
                if (tx_end) begin
                    d.tx_st = TX_DATA;
                    d.tx_bit = 4'h0;
                    d.tx_cyc = 16'h0;
                end
            end
            TX_DATA: begin
                line = q.tx_data[q.tx_bit];
                if (tx_end) begin
                    d.tx_cyc = 16'h0;
                    d.tx_bit = q.tx_bit + 4'h1;
                    if (q.tx_bit == nbits - 4'h1) begin
                        d.tx_st = par_on ? TX_PAR : TX_STOP;
                    end
                end
            end
            TX_PAR: begin
                line = par_calc(q.tx_data, q.line_format_control); // RULE22
                if (tx_end) begin
                    d.tx_st = TX_STOP;
                    d.tx_cyc = 16'h0;
                end
            end
            TX_STOP: begin
                if (q.tx_cyc == stop_len - 16'h1) begin
                    d.tx_st = TX_IDLE; // RULE21
                end
            end
            default: d.tx_st = TX_IDLE;
        endcase
        d.serial_output = q.line_format_control[`LCR_BREAK] ? 1'b0 : line; // RULE24
        // Receive shifter; bits sample the second sync stage, edge detect compares it with the third
        d.rx_cyc = q.rx_cyc + 16'h1;
        case (q.rx_st)
            RX_IDLE: begin
                if (q.sin_p && !q.sin_s) begin
                    d.rx_st = RX_START;
                    d.rx_cyc = 16'h0;
                end
            end
            RX_START: begin
                if (q.rx_cyc == HALFC - 16'h1) begin
                    d.rx_cyc = 16'h0;
                    d.rx_bit = 4'h0;
                    d.rx_data = 9'h000;
                    d.rx_st = q.sin_s ? RX_IDLE : RX_DATA; // RULE16
                end
            end
            RX_DATA: begin
                if (rx_end) begin
                    d.rx_cyc = 16'h0;
                    d.rx_data[q.rx_bit] = q.sin_s;
                    d.rx_bit = q.rx_bit + 4'h1;
                    d.rx_perr = 1'b0;
                    if (q.rx_bit == nbits - 4'h1) begin
                        d.rx_st = par_on ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_end) begin
                    d.rx_cyc = 16'h0;
                    d.rx_perr = (q.sin_s != par_calc(q.rx_data, q.line_format_control));
                    d.rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_end) begin
                    d.perr = q.rx_perr;
                    d.ferr = !q.sin_s;
                    d.ovr = rx_full && !rx_disable_in; // RULE18
                    d.rx_st = RX_IDLE; // RULE17
                end
            end
            default: d.rx_st = RX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            q <= '0;
            q.line_format_control <= `LCR_RESET;
            q.sin_m <= 1'b1;
            q.sin_s <= 1'b1;
            q.sin_p <= 1'b1;
            q.serial_output <= 1'b1;
            q.rx_st <= RX_IDLE;
            q.tx_st <= TX_IDLE;
        end else begin
            q <= d;
        end
    end

    assign rdata_out = q.rdata;
    assign rx_ninth_out = q.rx9;
    assign serial_output_out = q.serial_output;
    assign overrun_out = q.ovr;
    assign parity_err_out = q.perr;
    assign framing_err_out = q.ferr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_mid_high;
        q.rx_st == RX_START && q.rx_cyc == HALFC - 16'h1 && q.sin_s;
    endsequence

    sequence s_stop_full;
        q.rx_st == RX_STOP && rx_end && rx_full && !rx_disable_in;
    endsequence

    chk_false_start: assert property (s_mid_high |=> q.rx_st == RX_IDLE) // RULE16
        else $error("false start bit was accepted");
    chk_overrun_flag: assert property (s_stop_full |=> overrun_out) // RULE18
        else $error("overrun not flagged on full queue");
    chk_rx_store: assert property ((rx_push && !rx_pop) |=> // RULE17
        q.rx_cnt == $past(q.rx_cnt) + 8'h01)
        else $error("received character not stored");
    chk_tx_drop: assert property ((wr_tx && tx_full && !tx_pop && !flush_tx) // RULE3
        |=> q.tx_cnt == $past(q.tx_cnt))
        else $error("write to full transmit queue stored");
    chk_byte_depth: assert property (!q.fcr_en |-> q.rx_cnt <= 8'h01) // RULE2
        else $error("single-byte receive queue holds more than one");
    chk_flush_rx: assert property (flush_rx |=> q.rx_cnt == 8'h00) // RULE5
        else $error("receive queue not flushed");
    chk_unlock_write: assert property ((wr_lcr && wdata_in == `LCR_UNLOCK) // RULE19
        |=> q.line_format_control == {1'b1, $past(q.line_format_control[6:0])} && q.unlock)
        else $error("unlock write changed the format");
    chk_break_low: assert property (q.line_format_control[`LCR_BREAK] |=> !serial_output_out) // RULE24
        else $error("break did not hold the line low");
    chk_tx_irq: assert property ((tx_irq_en_in && !thr_sel_in && // RULE8
        q.tx_cnt == 8'h00) |-> tx_int_out)
        else $error("transmit interrupt missing on empty queue");
    chk_tx_thr_one: assert property ((q.fcr_en && !q.fcr3 && !thr_sel_in) // RULE6
        |-> tx_thr == `THR_ONE)
        else $error("transmit threshold not one");

endmodule // uart_fifo_line_format

`default_nettype wire

// [test/serial_terminal.sv]
// Remote serial terminal model, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
`default_nettype none

module serial_terminal #(
    parameter int BIT = 4
) (
    input wire logic clk_in,
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] got_q[$];

    // Line idles high between frames, as each stop bit leaves it
    initial line_out = 1'b1;

    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int k = 0; k < 10; k++) begin
            line_out <= f[k];
            repeat (BIT) @(posedge clk_in);
        end
    endtask

    // Short low pulse that a real start bit must outlast
    task automatic glitch();
        line_out <= 1'b0;
        @(posedge clk_in);
        line_out <= 1'b1;
        repeat (3 * BIT) @(posedge clk_in);
    endtask

    // Samples mid-bit; a bad stop bit is not judged here
    initial begin : rx_loop
        logic [7:0] b;
        forever begin
            @(negedge line_in);
            repeat (BIT / 2) @(posedge clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_in);
                b[i] = line_in;
            end
            repeat (BIT) @(posedge clk_in);
            got_q.push_back(b);
        end
    end
endmodule // serial_terminal

`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the serial channel queues and framing
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk, rstn, wr, rd, ninth, enh, nine, dis, tsel, pin;
    logic tien, rien, serial_input, serial_output, rninth, tint, rint, idle;
    logic ovr, perr, ferr, ovr_seen;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, tx_fill_level, rx_fill_level, low, v, g, b;
    logic [6:0] tthr, rthr;
    logic [7:0] d[$];
    logic [7:0] lvl[4] = '{8'h01, 8'h04, 8'h08, 8'h0E};
    int errors, comparisons, cyc;

    uart_fifo_line_format #(.BIT_CYCLES(4)) uut (
        .ref_clk_in(clk), .resetn_in(rstn), .addr_in(addr),
        .wr_in(wr), .rd_in(rd), .wdata_in(wdata), .rdata_out(rdata),
        .tx_ninth_in(ninth), .rx_ninth_out(rninth),
        .enhanced_mode_in(enh), .nine_bit_config_in(nine),
        .rx_disable_in(dis), .thr_sel_in(tsel), .tx_thr_reg_in(tthr),
        .rx_thr_reg_in(rthr), .depth_select_pin_in(pin),
        .tx_irq_en_in(tien), .rx_irq_en_in(rien),
        .serial_input_in(serial_input), .serial_output_out(serial_output),
        .tx_fill_level_out(tx_fill_level), .rx_fill_level_out(rx_fill_level),
        .lower_flow_level_out(low), .tx_int_out(tint),
        .rx_int_out(rint), .tx_idle_out(idle), .overrun_out(ovr),
        .parity_err_out(perr), .framing_err_out(ferr));

    serial_terminal #(.BIT(4)) term (
        .clk_in(clk), .line_in(serial_output), .line_out(serial_input));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ---------------------------------------------
    // Hang guard and overrun pulse catcher
    // ---------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (ovr === 1'b1) ovr_seen = 1'b1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    // One register access; read data lands the cycle after
    task automatic acc(input logic w, input logic [2:0] a,
                       input logic [7:0] x, output logic [7:0] r);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1 r = rdata;
    endtask

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h3225B022));
        {rstn, wr, rd, ninth, enh, nine, dis, tsel, pin} = '0;
        {tien, rien, addr, wdata, ovr_seen} = '0;
        tthr = 7'($urandom);
        rthr = 7'($urandom);
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk("line_idle", 8'h01, 8'(serial_output));
        chk("tx_idle", 8'h01, 8'(idle));
        // Format register, then unlock keeps the low bits
        v = 8'($urandom) & 8'h3F;
        acc(1'b1, 3'h3, v, g);
        acc(1'b0, 3'h3, 8'h00, g);
        chk("format", v, g);
        acc(1'b1, 3'h3, 8'hBF, g);
        acc(1'b0, 3'h3, 8'h00, g);
        chk("unlock", {1'b1, v[6:0]}, g);
        acc(1'b1, 3'h3, 8'h03, g);
        $display("test format done");
        // Transmit burst; trigger bits ignored outside enhanced mode
        tien <= 1'b1;
        acc(1'b1, 3'h2, 8'h39, g);
        for (int k = 0; k < 5; k++) begin
            b = 8'($urandom);
            d.push_back(b);
            acc(1'b1, 3'h0, b, g);
        end
        for (int k = 0; k < 3000 && idle !== 1'b1; k++) @(posedge clk);
        repeat (8) @(posedge clk);
        chk("tx_int", 8'h01, 8'(tint));
        chk("tx_count", 8'd5, 8'(term.got_q.size()));
        foreach (d[k]) chk("tx_byte", d[k], term.got_q[k]);
        $display("test transmit done");
        // Receive trigger levels, each after a flush
        rien <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            d.delete();
            acc(1'b1, 3'h2, {2'(c), 6'h03}, g);
            for (int k = 0; k < lvl[c]; k++) begin
                // Let the previous character land before judging
                if (k == lvl[c] - 1) begin
                    repeat (4) @(posedge clk);
                    chk("rx_int_low", 8'h00, 8'(rint));
                end
                b = 8'($urandom);
                d.push_back(b);
                term.send(b);
            end
            repeat (4) @(posedge clk);
            chk("rx_int", 8'h01, 8'(rint));
            chk("rx_fill", lvl[c], rx_fill_level);
            chk("low_none", 8'h00, low);
            chk("frame_ok", 8'h00, {6'h00, perr, ferr});
            foreach (d[k]) begin
                acc(1'b0, 3'h0, 8'h00, g);
                chk("rx_byte", d[k], g);
            end
        end
        $display("test receive done");
        enh <= 1'b1;
        acc(1'b1, 3'h2, 8'hC1, g);
        chk("lower_level", 8'h70, low);
        tsel <= 1'b1;
        @(posedge clk);
        #1;
        chk("sel_lower", 8'h01, low);
        {enh, tsel} <= 2'b00;
        term.glitch();
        chk("false_start", 8'h00, rx_fill_level);
        dis <= 1'b1;
        term.send(8'($urandom));
        // The character lands a cycle after the stop bit; wait past it
        repeat (4) @(posedge clk);
        chk("disabled", 8'h00, rx_fill_level);
        dis <= 1'b0;
        $display("test start reject done");
        // Byte mode keeps one entry; second character overruns
        acc(1'b1, 3'h2, 8'h00, g);
        ovr_seen = 1'b0;
        v = 8'($urandom);
        term.send(v);
        term.send(8'($urandom));
        repeat (4) @(posedge clk);
        chk("byte_fill", 8'h01, rx_fill_level);
        chk("overrun", 8'h01, 8'(ovr_seen));
        acc(1'b0, 3'h0, 8'h00, g);
        chk("kept_byte", v, g);
        chk("byte_low", 8'h01, low);
        $display("test byte mode done");
        acc(1'b1, 3'h3, 8'h43, g);
        repeat (2) @(posedge clk);
        #1;
        chk("break", 8'h00, 8'(serial_output));
        acc(1'b1, 3'h3, 8'h03, g);
        $display("test break done");
        results();
    end
endmodule // testbench

`default_nettype wire
